// [hdl/bwc_irq_pin_src.sv]
`timescale 1ns/10ps
module bwc_irq_pin_src (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// port role strap
	input wire logic strap_downstream,
	// override sources
	input wire logic smb_wr,
	input wire logic [7:0] smb_data,
	input wire logic ee_load,
	input wire logic [7:0] ee_data,
	// current value
	output logic [7:0] pin,
	output logic downstream
);
	import bwc_pkg::*;

	logic strap_taken;

	// strap caught on the first edge after release, never under reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_taken <= 1'b0;
			downstream <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			downstream <= strap_downstream;
		end
	end

	// smbus wins over a same-cycle eeprom load: it is the later intent
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin <= RST_IRQ_PIN;
		end else if (downstream && smb_wr) begin
			pin <= smb_data;
		end else if (downstream && ee_load) begin
			pin <= ee_data;
		end
	end
endmodule : bwc_irq_pin_src

// [hdl/bwc_range_cmp.sv]
`timescale 1ns/10ps
module bwc_range_cmp #(
	parameter int W = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// check request
	input wire logic chk_valid,
	input wire logic chk_qualify,
	input wire logic [W-1:0] chk_addr,
	// window bounds, already cut to the compared bits
	input wire logic [W-1:0] bottom,
	input wire logic [W-1:0] top,
	// result
	output logic hit
);
	logic next_hit;

	// inclusive bounds, inverted window off
	// an inverted window never matches, so software can park it
	always_comb begin
		next_hit = chk_qualify && (bottom <= top) &&
			(chk_addr >= bottom) && (chk_addr <= top);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hit <= 1'b0;
		end else if (chk_valid) begin
			hit <= next_hit;
		end else begin
			hit <= 1'b0;
		end
	end
endmodule : bwc_range_cmp

// [hdl/bwc_window_regs.sv]
`timescale 1ns/10ps
// Summary of operation
// - Non-prefetchable memory forwarded only inside memory base..top window.
// - Memory top field bits 31:20 gives top bits 31:20, low bits ones.
// - Prefetch window codes at bits 3:0 and 19:16 read 0001b only.
// - Prefetch bottom bits 15:4 give address 31:20, low twenty bits zero.
// - Prefetch top bits 31:20 give address 31:20, low twenty bits ones.
// - Offset 28h holds bottom address bits 63:32, used in forwarding.
// - Offset 2Ch holds top address bits 63:32, used in forwarding.
// - Offset 30h low half holds I/O bottom bits 31:16, reset zero.
// - Offset 30h high half holds I/O top bits 31:16, reset zero.
// - Capability pointer byte reads fixed 40h.
// - Interrupt pin byte is read-only to configuration writes.
// - Downstream ports take pin overrides from SMBus or EEPROM load.
// - I/O bottom treats address bits 11:0 as zero.
// - I/O top treats address bits 11:0 as all ones.
// - Memory bottom treats address bits 19:0 as zero.
module bwc_window_regs (
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// configuration access
	input wire logic CFG_WR,
	input wire logic CFG_RD,
	input wire logic [bwc_pkg::CFG_AW-1:0] CFG_ADDR,
	input wire logic [3:0] CFG_BE,
	input wire logic [bwc_pkg::CFG_DW-1:0] CFG_WDATA,
	output logic [bwc_pkg::CFG_DW-1:0] CFG_RDATA,
	output logic CFG_RDVALID,
	// neighbouring base fields kept outside this bank
	input wire logic [11:0] MEM_BOTTOM_FIELD,
	input wire logic [3:0] IO_BOTTOM_MID,
	input wire logic [3:0] IO_TOP_MID,
	// port role and interrupt pin overrides
	input wire logic PORT_DOWNSTREAM,
	input wire logic SMB_PIN_WR,
	input wire logic [7:0] SMB_PIN_DATA,
	input wire logic EE_PIN_LOAD,
	input wire logic [7:0] EE_PIN_DATA,
	output logic [7:0] IRQ_PIN,
	// forwarding check
	input wire logic CHK_VALID,
	input wire logic CHK_IO,
	input wire logic CHK_PREF,
	input wire logic [63:0] CHK_ADDR,
	output logic CHK_DONE,
	output logic MEM_HIT,
	output logic PREF_HIT,
	output logic IO_HIT,
	output logic FWD
);
	import bwc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [11:0] mem_top;
	logic [11:0] pref_bot;
	logic [11:0] pref_top;
	logic [31:0] pref_bot_hi;
	logic [31:0] pref_top_hi;
	logic [15:0] io_bot_hi;
	logic [15:0] io_top_hi;
	logic [7:0] irq_line;
	logic [7:0] irq_pin;
	logic downstream;
	logic [31:0] img_20;
	logic [31:0] img_24;
	logic [31:0] img_28;
	logic [31:0] img_2c;
	logic [31:0] img_30;
	logic [31:0] img_34;
	logic [31:0] img_3c;
	logic [31:0] next_20;
	logic [31:0] next_24;
	logic [31:0] next_30;
	logic [31:0] next_3c;
	logic [31:0] next_rdata;
	logic wr_20;
	logic wr_24;
	logic wr_28;
	logic wr_2c;
	logic wr_30;
	logic wr_3c;
	logic mem_ok;
	logic pref_ok;
	logic io_ok;
	logic mem_hit;
	logic pref_hit;
	logic io_hit;
	logic [7:0] dw_addr;

	////////////////////////////////////////////////////////////////////////
	// dword decode, byte offset bits ignored
	always_comb begin
		dw_addr = {CFG_ADDR[7:2], 2'b00};
		wr_20 = CFG_WR && (dw_addr == OFS_MEM_TOP);
		wr_24 = CFG_WR && (dw_addr == OFS_PREF_WIN);
		wr_28 = CFG_WR && (dw_addr == OFS_PREF_BOT_HI);
		wr_2c = CFG_WR && (dw_addr == OFS_PREF_TOP_HI);
		wr_30 = CFG_WR && (dw_addr == OFS_IO_HI);
		wr_3c = CFG_WR && (dw_addr == OFS_IRQ);
	end

	// read images
	always_comb begin
		img_20 = '0;
		img_20[POS_MEM_TOP +: 12] = mem_top;
		img_24 = '0;
		img_24[POS_PREF_BOT_CODE +: 4] = ADDR64_CODE;
		img_24[POS_PREF_TOP_CODE +: 4] = ADDR64_CODE;
		img_24[POS_PREF_BOT +: 12] = pref_bot;
		img_24[POS_PREF_TOP +: 12] = pref_top;
		img_28 = pref_bot_hi;
		img_2c = pref_top_hi;
		img_30 = '0;
		img_30[POS_IO_BOT +: 16] = io_bot_hi;
		img_30[POS_IO_TOP +: 16] = io_top_hi;
		img_34 = '0;
		img_34[7:0] = CAP_PTR_VAL;
		img_3c = '0;
		img_3c[POS_IRQ_LINE +: 8] = irq_line;
		img_3c[POS_IRQ_PIN +: 8] = irq_pin;
		next_24 = bwc_merge(img_24, CFG_WDATA, CFG_BE);
		next_30 = bwc_merge(img_30, CFG_WDATA, CFG_BE);
		next_20 = bwc_merge(img_20, CFG_WDATA, CFG_BE);
		next_3c = bwc_merge(img_3c, CFG_WDATA, CFG_BE);
	end

	////////////////////////////////////////////////////////////////////////
	// memory top field
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mem_top <= RST_MEM_FIELD;
		end else if (wr_20) begin
			mem_top <= next_20[POS_MEM_TOP +: 12];
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pref_bot <= RST_MEM_FIELD;
			pref_top <= RST_MEM_FIELD;
		end else if (wr_24) begin
			pref_bot <= next_24[POS_PREF_BOT +: 12];
			pref_top <= next_24[POS_PREF_TOP +: 12];
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pref_bot_hi <= RST_HIGH_WORD;
			pref_top_hi <= RST_HIGH_WORD;
		end else begin
			if (wr_28) begin
				pref_bot_hi <= bwc_merge(img_28, CFG_WDATA, CFG_BE);
			end
			if (wr_2c) begin
				pref_top_hi <= bwc_merge(img_2c, CFG_WDATA, CFG_BE);
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			io_bot_hi <= RST_IO_HALF;
			io_top_hi <= RST_IO_HALF;
		end else if (wr_30) begin
			io_bot_hi <= next_30[POS_IO_BOT +: 16];
			io_top_hi <= next_30[POS_IO_TOP +: 16];
		end
	end

	// interrupt line storage; pin byte ignores this write
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_line <= RST_IRQ_LINE;
		end else if (wr_3c) begin
			irq_line <= next_3c[POS_IRQ_LINE +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port: one cycle latency, unmapped reads return zero
	always_comb begin
		case (dw_addr)
			OFS_MEM_TOP: next_rdata = img_20;
			OFS_PREF_WIN: next_rdata = img_24;
			OFS_PREF_BOT_HI: next_rdata = img_28;
			OFS_PREF_TOP_HI: next_rdata = img_2c;
			OFS_IO_HI: next_rdata = img_30;
			OFS_CAP_PTR: next_rdata = img_34;
			OFS_IRQ: next_rdata = img_3c;
			default: next_rdata = RD_UNMAPPED;
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CFG_RDATA <= RD_UNMAPPED;
			CFG_RDVALID <= 1'b0;
		end else begin
			CFG_RDVALID <= CFG_RD;
			if (CFG_RD) begin
				CFG_RDATA <= next_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin override source, downstream ports only
	bwc_irq_pin_src u_pin (
		.clk(CLK),
		.arst_n(ARST_N),
		.strap_downstream(PORT_DOWNSTREAM),
		.smb_wr(SMB_PIN_WR),
		.smb_data(SMB_PIN_DATA),
		.ee_load(EE_PIN_LOAD),
		.ee_data(EE_PIN_DATA),
		.pin(irq_pin),
		.downstream(downstream)
	);

	assign IRQ_PIN = irq_pin;

	////////////////////////////////////////////////////////////////////////
	// window qualifiers: memory window lives below 4 GB only
	always_comb begin
		mem_ok = !CHK_IO && !CHK_PREF && (CHK_ADDR[63:32] == 32'h0000_0000);
		pref_ok = !CHK_IO && CHK_PREF;
		io_ok = CHK_IO && (CHK_ADDR[63:32] == 32'h0000_0000);
	end

	// only bits 31:20 compared: low bits zero at bottom
	// ones at top, so the ranges are exact
	bwc_range_cmp #(.W(12)) u_mem (
		.clk(CLK),
		.arst_n(ARST_N),
		.chk_valid(CHK_VALID),
		.chk_qualify(mem_ok),
		.chk_addr(CHK_ADDR[31:20]),
		.bottom(MEM_BOTTOM_FIELD),
		.top(mem_top),
		.hit(mem_hit)
	);

	// 44-bit prefetch compare on address bits 63:20
	bwc_range_cmp #(.W(44)) u_pref (
		.clk(CLK),
		.arst_n(ARST_N),
		.chk_valid(CHK_VALID),
		.chk_qualify(pref_ok),
		.chk_addr(CHK_ADDR[63:20]),
		.bottom({pref_bot_hi, pref_bot}),
		.top({pref_top_hi, pref_top}),
		.hit(pref_hit)
	);

	bwc_range_cmp #(.W(20)) u_io (
		.clk(CLK),
		.arst_n(ARST_N),
		.chk_valid(CHK_VALID),
		.chk_qualify(io_ok),
		.chk_addr(CHK_ADDR[31:12]),
		.bottom({io_bot_hi, IO_BOTTOM_MID}),
		.top({io_top_hi, IO_TOP_MID}),
		.hit(io_hit)
	);

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CHK_DONE <= 1'b0;
		end else begin
			CHK_DONE <= CHK_VALID;
		end
	end

	assign MEM_HIT = mem_hit;
	assign PREF_HIT = pref_hit;
	assign IO_HIT = io_hit;
	assign FWD = mem_hit || pref_hit || io_hit;

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	a_cap_ptr_fixed: assert property (
		CFG_RD && dw_addr == OFS_CAP_PTR |=> CFG_RDVALID &&
			CFG_RDATA == 32'h0000_0040)
		else $error("capability pointer read not 40h");

	a_pref_codes_fixed: assert property (
		CFG_WR && dw_addr == OFS_PREF_WIN ##[1:2] CFG_RD &&
			dw_addr == OFS_PREF_WIN |=> CFG_RDATA[3:0] == 4'h1 &&
			CFG_RDATA[19:16] == 4'h1)
		else $error("prefetch code bits not 0001b after write");

	a_mem_top_hit: assert property (
		CHK_VALID && mem_ok && CHK_ADDR[31:20] >= MEM_BOTTOM_FIELD &&
			CHK_ADDR[31:20] <= mem_top |=> MEM_HIT && FWD)
		else $error("address inside memory window not forwarded");

	a_empty_window: assert property (
		CHK_VALID && MEM_BOTTOM_FIELD > mem_top |=> !MEM_HIT)
		else $error("inverted memory window matched");

	a_pref_hi_write: assert property (
		wr_28 && CFG_BE == 4'hF |=> pref_bot_hi == $past(CFG_WDATA)
			##2 (!$past(CFG_RD && dw_addr == OFS_PREF_BOT_HI) ||
			CFG_RDATA == $past(pref_bot_hi)))
		else $error("prefetch bottom high word not written");

	a_pref_top_hi_write: assert property (
		wr_2c && CFG_BE == 4'hF |=> pref_top_hi == $past(CFG_WDATA))
		else $error("prefetch top high word not written");

	a_io_halves: assert property (
		wr_30 && CFG_BE == 4'hC |=> io_top_hi == $past(CFG_WDATA[31:16])
			&& $stable(io_bot_hi))
		else $error("io top half write wrong or leaked");

	a_pin_readonly: assert property (
		wr_3c && !SMB_PIN_WR && !EE_PIN_LOAD |=> $stable(irq_pin))
		else $error("configuration write changed interrupt pin");

	a_pin_override: assert property (
		downstream && SMB_PIN_WR |=> irq_pin == $past(SMB_PIN_DATA))
		else $error("smbus override of interrupt pin lost");

	a_line_store: assert property (
		wr_3c && CFG_BE[0] |=> irq_line == $past(CFG_WDATA[7:0]) &&
			$stable(mem_top))
		else $error("interrupt line not stored");

	c_pref_hit: cover property (CHK_VALID && pref_ok ##1 PREF_HIT);
	c_io_hit: cover property (CHK_VALID && io_ok ##1 IO_HIT);
	c_ee_load: cover property (downstream && EE_PIN_LOAD ##1 irq_pin != 8'h00);
	c_mem_miss: cover property (CHK_VALID && mem_ok ##1 !MEM_HIT);
endmodule : bwc_window_regs

// [shared/bwc_pkg.sv]
package bwc_pkg;
	// configuration dword byte offsets
	localparam logic [7:0] OFS_MEM_TOP = 8'h20;
	localparam logic [7:0] OFS_PREF_WIN = 8'h24;
	localparam logic [7:0] OFS_PREF_BOT_HI = 8'h28;
	localparam logic [7:0] OFS_PREF_TOP_HI = 8'h2C;
	localparam logic [7:0] OFS_IO_HI = 8'h30;
	localparam logic [7:0] OFS_CAP_PTR = 8'h34;
	localparam logic [7:0] OFS_IRQ = 8'h3C;
	localparam int CFG_AW = 8;
	localparam int CFG_DW = 32;
	// field positions (low bit of each field)
	localparam int POS_MEM_TOP = 20;
	localparam int POS_PREF_BOT = 4;
	localparam int POS_PREF_TOP = 20;
	localparam int POS_PREF_BOT_CODE = 0;
	localparam int POS_PREF_TOP_CODE = 16;
	localparam int POS_IO_BOT = 0;
	localparam int POS_IO_TOP = 16;
	localparam int POS_IRQ_LINE = 0;
	localparam int POS_IRQ_PIN = 8;
	// values after reset and fixed read values
	localparam logic [11:0] RST_MEM_FIELD = 12'h000;
	localparam logic [31:0] RST_HIGH_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_IO_HALF = 16'h0000;
	localparam logic [7:0] RST_IRQ_LINE = 8'h00;
	localparam logic [7:0] RST_IRQ_PIN = 8'h00;
	localparam logic [3:0] ADDR64_CODE = 4'h1;
	localparam logic [7:0] CAP_PTR_VAL = 8'h40;
	localparam logic [CFG_DW-1:0] RD_UNMAPPED = 32'h0000_0000;

	// byte-lane merge of a write into the current dword image
	function automatic logic [31:0] bwc_merge(input logic [31:0] old_word,
		input logic [31:0] new_word, input logic [3:0] be);
		logic [31:0] res;
		res = old_word;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		return res;
	endfunction : bwc_merge
endpackage : bwc_pkg

// [verification/test_bridge_window_config_regs.sv]
`timescale 1ns/10ps
module test_bridge_window_config_regs;
	import bwc_pkg::*;

	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [3:0] cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0000_0000;
	logic [31:0] cfg_rdata;
	logic cfg_rdvalid;
	logic [11:0] mem_bottom = 12'h000;
	logic [3:0] io_bot_mid = 4'h0;
	logic [3:0] io_top_mid = 4'h0;
	logic port_downstream = 1'b0;
	logic smb_wr = 1'b0;
	logic [7:0] smb_data = 8'h00;
	logic ee_load = 1'b0;
	logic [7:0] ee_data = 8'h00;
	logic [7:0] irq_pin;
	logic chk_valid = 1'b0;
	logic chk_io = 1'b0;
	logic chk_pref = 1'b0;
	logic [63:0] chk_addr = 64'h0000_0000_0000_0000;
	logic chk_done, mem_hit, pref_hit, io_hit, fwd;
	int n_mismatch = 0;
	int compares = 0;

	bwc_window_regs dut (.CLK(clk), .ARST_N(arst_n), .CFG_WR(cfg_wr),
		.CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be),
		.CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
		.CFG_RDVALID(cfg_rdvalid), .MEM_BOTTOM_FIELD(mem_bottom),
		.IO_BOTTOM_MID(io_bot_mid), .IO_TOP_MID(io_top_mid),
		.PORT_DOWNSTREAM(port_downstream), .SMB_PIN_WR(smb_wr),
		.SMB_PIN_DATA(smb_data), .EE_PIN_LOAD(ee_load),
		.EE_PIN_DATA(ee_data), .IRQ_PIN(irq_pin), .CHK_VALID(chk_valid),
		.CHK_IO(chk_io), .CHK_PREF(chk_pref), .CHK_ADDR(chk_addr),
		.CHK_DONE(chk_done), .MEM_HIT(mem_hit), .PREF_HIT(pref_hit),
		.IO_HIT(io_hit), .FWD(fwd));

	initial begin
		forever #2.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done

	task automatic expect_val(input logic [63:0] got, input logic [63:0] exp,
		input string msg);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h", $time, msg, got);
		end
	endtask : expect_val

	task automatic do_reset(input logic strap);
		@(negedge clk);
		arst_n = 1'b0;
		port_downstream = strap;
		repeat (6) @(negedge clk);
		arst_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask : do_reset

	task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		@(negedge clk);
		cfg_wr = 1'b0;
		cfg_wdata = ~d;
	endtask : cfg_write

	// answer lands one edge after the strobe
	task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
		@(negedge clk);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge clk);
		cfg_rd = 1'b0;
		expect_val({31'h0, cfg_rdvalid, cfg_rdata}, {31'h0, 1'b1, exp}, "read");
	endtask : cfg_read

	// exp holds mem, prefetch and io hits in that order
	task automatic fwd_check(input logic io, input logic pref,
		input logic [63:0] a, input logic [2:0] exp);
		@(negedge clk);
		chk_valid = 1'b1;
		chk_io = io;
		chk_pref = pref;
		chk_addr = a;
		@(negedge clk);
		chk_valid = 1'b0;
		chk_addr = ~a;
		expect_val({chk_done, mem_hit, pref_hit, io_hit, fwd},
			{1'b1, exp, |exp}, "forward");
	endtask : fwd_check

	task automatic pin_pulse(input logic s, input logic [7:0] sd,
		input logic e, input logic [7:0] ed, input logic [7:0] exp);
		@(negedge clk);
		smb_wr = s;
		smb_data = sd;
		ee_load = e;
		ee_data = ed;
		@(negedge clk);
		smb_wr = 1'b0;
		ee_load = 1'b0;
		expect_val(irq_pin, exp, "pin");
	endtask : pin_pulse

	////////////////////////////////////////////////////////////////////
	task automatic t_access;
		logic [7:0] ofs [8] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34,
			8'h38, 8'h3C};
		logic [31:0] rst [8] = '{32'h0000_0000, 32'h0001_0001, 32'h0000_0000,
			32'h0000_0000, 32'h0000_0000, 32'h0000_0040, 32'h0000_0000,
			32'h0000_0000};
		logic [31:0] ones [8] = '{32'hFFF0_0000, 32'hFFF1_FFF1, 32'hFFFF_FFFF,
			32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0040, 32'h0000_0000,
			32'h0000_00FF};
		for (int i = 0; i < 8; i++) begin
			cfg_read(ofs[i], rst[i]);
		end
		for (int i = 0; i < 8; i++) begin
			cfg_write(ofs[i], 4'hF, 32'hFFFF_FFFF);
			cfg_read(ofs[i], ones[i]);
		end
		cfg_write(8'h20, 4'b1000, 32'h0000_0000);
		cfg_read(8'h20, 32'h00F0_0000);
		cfg_write(8'h30, 4'b0011, 32'h0000_1234);
		cfg_read(8'h30, 32'hFFFF_1234);
		cfg_write(8'h30, 4'b1100, 32'h5678_0000);
		cfg_read(8'h30, 32'h5678_1234);
		$display("test access done");
	endtask : t_access

	task automatic t_mem_window;
		cfg_write(8'h20, 4'hF, 32'h0030_0000);
		mem_bottom = 12'h002;
		fwd_check(1'b0, 1'b0, 64'h0000_0000_0020_0000, 3'b100);
		fwd_check(1'b0, 1'b0, 64'h0000_0000_003F_FFFF, 3'b100);
		fwd_check(1'b0, 1'b0, 64'h0000_0000_0040_0000, 3'b000);
		fwd_check(1'b0, 1'b0, 64'h0000_0000_001F_FFFF, 3'b000);
		fwd_check(1'b0, 1'b0, 64'h0000_0001_0020_0000, 3'b000);
		mem_bottom = 12'h004;
		fwd_check(1'b0, 1'b0, 64'h0000_0000_0040_0000, 3'b000);
		fwd_check(1'b0, 1'b0, 64'h0000_0000_0030_0000, 3'b000);
		$display("test memory window done");
	endtask : t_mem_window

	task automatic t_pref_window;
		cfg_write(8'h24, 4'hF, 32'h0020_0010);
		cfg_write(8'h28, 4'hF, 32'h0000_0001);
		cfg_write(8'h2C, 4'hF, 32'h0000_0001);
		fwd_check(1'b0, 1'b1, 64'h0000_0001_0010_0000, 3'b010);
		fwd_check(1'b0, 1'b1, 64'h0000_0001_002F_FFFF, 3'b010);
		fwd_check(1'b0, 1'b1, 64'h0000_0001_0030_0000, 3'b000);
		fwd_check(1'b0, 1'b1, 64'h0000_0001_000F_FFFF, 3'b000);
		fwd_check(1'b0, 1'b1, 64'h0000_0000_0010_0000, 3'b000);
		cfg_write(8'h2C, 4'hF, 32'h0000_0002);
		fwd_check(1'b0, 1'b1, 64'h0000_0002_0000_0000, 3'b010);
		cfg_write(8'h28, 4'hF, 32'h0000_0003);
		fwd_check(1'b0, 1'b1, 64'h0000_0002_0000_0000, 3'b000);
		$display("test prefetch window done");
	endtask : t_pref_window

	task automatic t_io_window;
		cfg_write(8'h30, 4'hF, 32'h0002_0001);
		io_bot_mid = 4'h1;
		io_top_mid = 4'h2;
		fwd_check(1'b1, 1'b0, 64'h0000_0000_0001_1000, 3'b001);
		fwd_check(1'b1, 1'b0, 64'h0000_0000_0001_0FFF, 3'b000);
		fwd_check(1'b1, 1'b0, 64'h0000_0000_0002_2FFF, 3'b001);
		fwd_check(1'b1, 1'b0, 64'h0000_0000_0002_3000, 3'b000);
		fwd_check(1'b1, 1'b0, 64'h0000_0001_0001_1000, 3'b000);
		$display("test io window done");
	endtask : t_io_window

	task automatic t_irq_pin;
		do_reset(1'b0);
		pin_pulse(1'b1, 8'h01, 1'b0, 8'h00, 8'h00);
		pin_pulse(1'b0, 8'h00, 1'b1, 8'h07, 8'h00);
		do_reset(1'b1);
		cfg_read(8'h3C, 32'h0000_0000);
		pin_pulse(1'b1, 8'h01, 1'b0, 8'h00, 8'h01);
		cfg_read(8'h3C, 32'h0000_0100);
		pin_pulse(1'b0, 8'h00, 1'b1, 8'h05, 8'h05);
		pin_pulse(1'b1, 8'h02, 1'b1, 8'h03, 8'h02);
		cfg_write(8'h3C, 4'hF, 32'h0000_FF5A);
		cfg_read(8'h3C, 32'h0000_025A);
		$display("test interrupt pin done");
	endtask : t_irq_pin

	////////////////////////////////////////////////////////////////////
	// a stuck run still ends with a verdict
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("wrong value at %0t: run did not finish", $time);
		test_done();
	end

	initial begin
		do_reset(1'b1);
		t_access();
		t_mem_window();
		t_pref_window();
		t_io_window();
		t_irq_pin();
		test_done();
	end
endmodule : test_bridge_window_config_regs
